// File: include/fce_cfg.svh
// fault classify/escalate constants: offsets, fields, return value checks, resets
`ifndef FCE_CFG_SVH
`define FCE_CFG_SVH
// Summary of operation
// - bus error on vector read gives hard fault and sets vector-read flag
// - any promotion of a configurable fault to hard fault sets escalation flag
// - protection-mismatched fetch, or fetch from non-executable region, is memmanage
// - data access protection mismatch gives memmanage fault, data-access flag
// - stacking/unstacking protection mismatch sets its own memmanage flag
// - stacking/unstacking bus error sets its own bus fault flag
// - prefetch bus error gives bus fault and prefetch flag
// - data bus error sets precise or imprecise flag by attribution
// - coprocessor, undefined, invalid state give usage fault and flags
// - bad return value, unaligned access, divide by zero give usage fault
// - invalid state covers other instruction set or bad continuation return
// - configurable faults have software priority and individual enables
// - handler raising its own fault kind escalates to hard fault
// - fault not above current execution priority escalates to hard fault
// - fault whose handler is disabled escalates to hard fault
// - bus fault on stacking into bus fault handler does not escalate
// - hard fault preempts all but reset, nmi and hard fault
// - precise data bus faults and fetch/data-access memmanage faults capture the faulting address
// - hard fault inside nmi or hard fault handler enters lockup
// - lockup holds until reset, nmi or debugger halt request
// - lockup entered from nmi handler is not released by nmi
// - return value needs bits 31:4 set and valid low-nibble code

// register offsets (byte addresses)
`define FCE_OFF_HFSR     8'h00
`define FCE_OFF_MMFSR    8'h04
`define FCE_OFF_BFSR     8'h08
`define FCE_OFF_UFSR     8'h0C
`define FCE_OFF_MMAR     8'h10
`define FCE_OFF_BFAR     8'h14
`define FCE_OFF_PRI      8'h18
`define FCE_OFF_EN       8'h1C
`define FCE_OFF_STATE    8'h20

// hard fault status fields
`define FCE_HF_VECTOR_READ_FLAG      0
`define FCE_HF_ESC       1
// memmanage fields
`define FCE_MM_IACC      0
`define FCE_MM_DACC      1
`define FCE_MM_UNSTK     2
`define FCE_MM_STK       3
// bus fault fields
`define FCE_BF_PREFETCH_BUS_ERROR_FLAG      0
`define FCE_BF_PRECISE   1
`define FCE_BF_IMPRECISE_ERROR_FLAG     2
`define FCE_BF_UNSTK     3
`define FCE_BF_STK       4
// usage fault fields
`define FCE_UF_UNDEFINED_INSTR_FLAG     0
`define FCE_UF_INVSTATE  1
`define FCE_UF_INVRET    2
`define FCE_UF_NO_COPROCESSOR_FLAG      3
`define FCE_UF_UNALIGNED_FLAG   4
`define FCE_UF_DIVZ      5

// exception return value checks
`define FCE_RET_UPPER    28'hFFFFFFF
`define FCE_RET_HANDLER  4'h1
`define FCE_RET_THREAD   4'h9
`define FCE_RET_PROCESS  4'hD

// reset values
`define FCE_PRI_RESET    24'h000000
`define FCE_EN_RESET     3'h0
`define FCE_ZERO32       32'h00000000
`endif

// File: include/fce_pkg.sv
// fault classify/escalate types
package fce_pkg;
    // handler identities; lower priority value is more urgent
    typedef enum logic [2:0] {
        FCE_H_NONE   = 3'h0,
        FCE_H_MEM    = 3'h1,
        FCE_H_BUS    = 3'h2,
        FCE_H_USAGE  = 3'h3,
        FCE_H_HARD   = 3'h4,
        FCE_H_NMI    = 3'h5,
        FCE_H_OTHER  = 3'h6
    } fce_handler_t;

    typedef enum logic [1:0] {
        FCE_RUN      = 2'b00,
        FCE_LOCK     = 2'b01,
        FCE_LOCK_NMI = 2'b11
    } fce_state_t;

    // fault events from pipeline, bus interface and protection unit
    typedef struct packed {
        logic vector_bus_err;
        logic fetch_mismatch;
        logic fetch_nonexec;
        logic data_mismatch;
        logic stack_mismatch;
        logic unstack_mismatch;
        logic stack_bus_err;
        logic unstack_bus_err;
        logic prefetch_bus_err;
        logic data_bus_err;
        logic data_bus_precise;
        logic coproc;
        logic undefined_instr_flag_instr;
        logic other_iset;
        logic bad_continuation;
        logic ret_check;
        logic unaligned;
        logic div_zero;
    } fce_events_t;

    // current execution context
    typedef struct packed {
        fce_handler_t handler;
        logic [7:0]   priority_level;
        logic         in_handler;
    } fce_context_t;

    typedef struct packed {
        logic         take;
        fce_handler_t handler;
    } fce_dispatch_t;
endpackage

// File: core/fce_fault_unit.sv
// fault classify/escalate unit with register port
`timescale 1ns/100ps
`default_nettype none
`include "fce_cfg.svh"
module fce_fault_unit #(
    parameter int ADDR_W = 8
) (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire fce_pkg::fce_events_t  events,
    input  wire logic [31:0]           exception_return_value,
    input  wire logic [31:0]           fault_addr,
    input  wire fce_pkg::fce_context_t ctx,
    input  wire logic                  nmi,
    input  wire logic                  debug_halt,
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [31:0]           wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic [31:0]                rdata,
    output fce_pkg::fce_dispatch_t     dispatch,
    output logic                       lockup
);
    // ----------
    // classification
    // ----------
    logic [1:0] hf_set;
    logic [3:0] mm_set;
    logic [4:0] bf_set;
    logic [5:0] uf_set;
    logic       ret_bad;
    logic       mm_raise;
    logic       bf_raise;
    logic       uf_raise;

    // return value is checked only when the pipeline flags a return
    assign ret_bad = events.ret_check &&
        (exception_return_value[31:4] != `FCE_RET_UPPER ||
         !(exception_return_value[3:0] == `FCE_RET_HANDLER ||
           exception_return_value[3:0] == `FCE_RET_THREAD ||
           exception_return_value[3:0] == `FCE_RET_PROCESS));

    always_comb begin
        mm_set = '0;
        mm_set[`FCE_MM_IACC]  = events.fetch_mismatch ||
                                events.fetch_nonexec;
        mm_set[`FCE_MM_DACC]  = events.data_mismatch;
        mm_set[`FCE_MM_STK]   = events.stack_mismatch;
        mm_set[`FCE_MM_UNSTK] = events.unstack_mismatch;

        bf_set = '0;
        bf_set[`FCE_BF_STK]     = events.stack_bus_err;
        bf_set[`FCE_BF_UNSTK]   = events.unstack_bus_err;
        bf_set[`FCE_BF_PREFETCH_BUS_ERROR_FLAG]    = events.prefetch_bus_err;
        bf_set[`FCE_BF_PRECISE] = events.data_bus_err &&
                                  events.data_bus_precise;
        bf_set[`FCE_BF_IMPRECISE_ERROR_FLAG]   = events.data_bus_err &&
                                  !events.data_bus_precise;

        uf_set = '0;
        uf_set[`FCE_UF_NO_COPROCESSOR_FLAG]     = events.coproc;
        uf_set[`FCE_UF_UNDEFINED_INSTR_FLAG]    = events.undefined_instr_flag_instr;
        uf_set[`FCE_UF_INVSTATE] = events.other_iset ||
                                   events.bad_continuation;
        uf_set[`FCE_UF_INVRET]   = ret_bad;
        uf_set[`FCE_UF_UNALIGNED_FLAG]  = events.unaligned;
        uf_set[`FCE_UF_DIVZ]     = events.div_zero;
    end

    assign mm_raise = |mm_set;
    assign bf_raise = |bf_set;
    assign uf_raise = |uf_set;

    // ----------
    // configuration registers
    // ----------
    // priority bytes: mem [7:0], bus [15:8], usage [23:16]
    logic [23:0] fault_priority_config;
    // enables: mem 0, bus 1, usage 2; all off after reset
    logic [2:0]  fault_handler_enables;
    logic        sel_pri;
    logic        sel_en;

    assign sel_pri = wr && addr == ADDR_W'(`FCE_OFF_PRI);
    assign sel_en  = wr && addr == ADDR_W'(`FCE_OFF_EN);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fault_priority_config <= `FCE_PRI_RESET;
            fault_handler_enables <= `FCE_EN_RESET;
        end else begin
            if (sel_pri) begin
                fault_priority_config <= wdata[23:0];
            end

            if (sel_en) begin
                fault_handler_enables <= wdata[2:0];
            end
        end
    end

    // ----------
    // escalation and dispatch
    // ----------
    // one fault is taken per cycle: memmanage, then bus, then usage
    // the others keep only their flags
    fce_pkg::fce_handler_t fault_kind;
    logic [7:0]            fault_pri;
    logic                  fault_en;
    logic                  any_fault;
    logic                  stack_into_bus;
    logic                  escalate;
    logic                  hard_now;
    logic                  in_nmi;
    logic                  in_hard;

    always_comb begin
        fault_kind = fce_pkg::FCE_H_NONE;
        fault_pri  = 8'h00;
        fault_en   = 1'b0;
        if (mm_raise) begin
            fault_kind = fce_pkg::FCE_H_MEM;
            fault_pri  = fault_priority_config[7:0];
            fault_en   = fault_handler_enables[0];
        end else if (bf_raise) begin
            fault_kind = fce_pkg::FCE_H_BUS;
            fault_pri  = fault_priority_config[15:8];
            fault_en   = fault_handler_enables[1];
        end else if (uf_raise) begin
            fault_kind = fce_pkg::FCE_H_USAGE;
            fault_pri  = fault_priority_config[23:16];
            fault_en   = fault_handler_enables[2];
        end
    end

    assign any_fault = mm_raise || bf_raise || uf_raise;
    assign in_nmi  = ctx.in_handler && ctx.handler == fce_pkg::FCE_H_NMI;
    assign in_hard = ctx.in_handler && ctx.handler == fce_pkg::FCE_H_HARD;
    // stacking bus error on entry to the bus handler is let through
    assign stack_into_bus = fault_kind == fce_pkg::FCE_H_BUS &&
                            events.stack_bus_err &&
                            ctx.handler == fce_pkg::FCE_H_BUS;

    // equal priority cannot preempt, so it escalates too
    always_comb begin
        escalate = 1'b0;
        if (any_fault && !stack_into_bus) begin
            if (!fault_en) begin
                escalate = 1'b1;
            end else if (ctx.in_handler && ctx.handler == fault_kind) begin
                escalate = 1'b1;
            end else if (ctx.in_handler &&
                         ctx.priority_level <= fault_pri) begin
                escalate = 1'b1;
            end
        end
    end

    // vector errors skip the configurable handlers
    assign hard_now = events.vector_bus_err || escalate;

    fce_pkg::fce_state_t state;
    fce_pkg::fce_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            fce_pkg::FCE_RUN: begin
                if (hard_now && (in_nmi || in_hard)) begin
                    next_state = in_nmi ? fce_pkg::FCE_LOCK_NMI
                                        : fce_pkg::FCE_LOCK;
                end
            end

            fce_pkg::FCE_LOCK: begin
                if (nmi || debug_halt) begin
                    next_state = fce_pkg::FCE_RUN;
                end
            end

            // a later nmi cannot free this state
            fce_pkg::FCE_LOCK_NMI: begin
                if (debug_halt) begin
                    next_state = fce_pkg::FCE_RUN;
                end
            end

            // code 2'b10 is unused; fall back to run
            default: next_state = fce_pkg::FCE_RUN;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= fce_pkg::FCE_RUN;
        end else begin
            state <= next_state;
        end
    end

    // no dispatch at all while this stands
    assign lockup = state != fce_pkg::FCE_RUN;

    // hard fault preempts anything but nmi and another hard fault
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dispatch <= '0;
        end else begin
            dispatch.take    <= 1'b0;
            dispatch.handler <= fce_pkg::FCE_H_NONE;

            if (state == fce_pkg::FCE_RUN) begin
                if (hard_now) begin
                    if (!in_nmi && !in_hard) begin
                        dispatch.take    <= 1'b1;
                        dispatch.handler <= fce_pkg::FCE_H_HARD;
                    end
                end else if (any_fault) begin
                    dispatch.take    <= 1'b1;
                    dispatch.handler <= fault_kind;
                end
            end
        end
    end

    // ----------
    // status registers, write one to clear; address registers, not writable
    // ----------
    logic [1:0]  hard_fault_status;
    logic [3:0]  mem_manage_fault_status;
    logic [4:0]  bus_fault_status;
    logic [5:0]  usage_fault_status;
    logic [31:0] mem_manage_fault_address;
    logic [31:0] bus_fault_address;

    always_comb begin
        hf_set = '0;
        hf_set[`FCE_HF_VECTOR_READ_FLAG] = events.vector_bus_err;
        hf_set[`FCE_HF_ESC]  = escalate;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hard_fault_status       <= '0;
            mem_manage_fault_status <= '0;
            bus_fault_status        <= '0;
            usage_fault_status      <= '0;
        end else begin
            hard_fault_status <= (hard_fault_status &
                ~((wr && addr == ADDR_W'(`FCE_OFF_HFSR)) ? wdata[1:0]
                  : 2'h0)) | hf_set;

            mem_manage_fault_status <= (mem_manage_fault_status &
                ~((wr && addr == ADDR_W'(`FCE_OFF_MMFSR)) ? wdata[3:0]
                  : 4'h0)) | mm_set;

            bus_fault_status <= (bus_fault_status &
                ~((wr && addr == ADDR_W'(`FCE_OFF_BFSR)) ? wdata[4:0]
                  : 5'h00)) | bf_set;

            usage_fault_status <= (usage_fault_status &
                ~((wr && addr == ADDR_W'(`FCE_OFF_UFSR)) ? wdata[5:0]
                  : 6'h00)) | uf_set;
        end
    end

    // imprecise errors carry no trustworthy address
    // stacking faults leave the addresses alone
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mem_manage_fault_address <= `FCE_ZERO32;
            bus_fault_address        <= `FCE_ZERO32;
        end else begin
            if (events.data_mismatch || events.fetch_mismatch ||
                events.fetch_nonexec) begin
                mem_manage_fault_address <= fault_addr;
            end

            if (events.data_bus_err && events.data_bus_precise) begin
                bus_fault_address <= fault_addr;
            end
        end
    end

    // ----------
    // read port, data valid one cycle after the strobe
    // ----------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= `FCE_ZERO32;
        end else begin
            rdata <= `FCE_ZERO32;
            if (rd) begin
                unique case (addr)
                    ADDR_W'(`FCE_OFF_HFSR):
                        rdata <= {30'h0, hard_fault_status};

                    ADDR_W'(`FCE_OFF_MMFSR):
                        rdata <= {28'h0, mem_manage_fault_status};

                    ADDR_W'(`FCE_OFF_BFSR):
                        rdata <= {27'h0, bus_fault_status};

                    ADDR_W'(`FCE_OFF_UFSR):
                        rdata <= {26'h0, usage_fault_status};

                    ADDR_W'(`FCE_OFF_MMAR):
                        rdata <= mem_manage_fault_address;

                    ADDR_W'(`FCE_OFF_BFAR):
                        rdata <= bus_fault_address;

                    ADDR_W'(`FCE_OFF_PRI):
                        rdata <= {8'h0, fault_priority_config};

                    ADDR_W'(`FCE_OFF_EN):
                        rdata <= {29'h0, fault_handler_enables};

                    ADDR_W'(`FCE_OFF_STATE):
                        rdata <= {30'h0, state};

                    default:
                        rdata <= `FCE_ZERO32;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/fce_fault_unit_asserts.sv
// port-level assertions for the fault classify/escalate unit
`timescale 1ns/100ps
`default_nettype none
`include "fce_cfg.svh"
module fce_fault_unit_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic                   mclk,
    input wire logic                   arst_n,
    input wire fce_pkg::fce_events_t   events,
    input wire fce_pkg::fce_context_t  ctx,
    input wire logic                   nmi,
    input wire logic                   debug_halt,
    input wire logic [ADDR_W-1:0]      addr,
    input wire logic [31:0]            wdata,
    input wire logic                   wr,
    input wire fce_pkg::fce_dispatch_t dispatch,
    input wire logic                   lockup
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [2:0] en_q;
    logic       from_nmi;
    logic       only_dz;
    logic       hard_ctx;
    assign only_dz  = (events == 18'h00001);
    assign hard_ctx = ctx.in_handler && (ctx.handler == fce_pkg::FCE_H_HARD
                      || ctx.handler == fce_pkg::FCE_H_NMI);
    // ----------
    // shadow state
    // ----------
    // enables are not visible at the ports, so mirror the writes
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) en_q <= 3'h0;
        else if (wr && addr == `FCE_OFF_EN) en_q <= wdata[2:0];
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) from_nmi <= 1'h0;
        else if (!lockup) from_nmi <= (ctx.handler == fce_pkg::FCE_H_NMI);
    end
    // ----------
    // assertions
    // ----------
    AST_TAKE_CAUSE: assert property (
        dispatch.take |-> $past(events) != 18'h00000)
        else $error("take without cause");
    AST_NO_DISP_LOCK: assert property (
        lockup |-> !dispatch.take)
        else $error("take in lockup");
    AST_LOCK_ENTRY: assert property (
        events.vector_bus_err && hard_ctx && !nmi && !debug_halt |=> lockup)
        else $error("no lockup entry");
    AST_LOCK_HOLD: assert property (
        lockup && !debug_halt && !nmi |=> lockup)
        else $error("lockup dropped");
    AST_NMI_KEEP: assert property (
        lockup && from_nmi && !debug_halt |=> lockup)
        else $error("nmi freed nmi lockup");
    AST_NMI_FREE: assert property (
        lockup && nmi && !from_nmi && !debug_halt && events == 18'h00000
        |=> !lockup)
        else $error("nmi kept lockup");
    AST_DBG_FREE: assert property (
        lockup && debug_halt && events == 18'h00000 |=> !lockup)
        else $error("halt kept lockup");
    AST_VECTOR_READ_FLAG_HARD: assert property (
        events.vector_bus_err && !ctx.in_handler && !lockup
        |=> dispatch.take && dispatch.handler == fce_pkg::FCE_H_HARD)
        else $error("vector not hard");
    AST_ESC_OFF: assert property (
        only_dz && !en_q[2] && !ctx.in_handler && !lockup
        |=> dispatch.take && dispatch.handler == fce_pkg::FCE_H_HARD)
        else $error("off usage not hard");
    AST_USAGE_DISP: assert property (
        only_dz && en_q[2] && !ctx.in_handler && !lockup
        |=> dispatch.take && dispatch.handler == fce_pkg::FCE_H_USAGE)
        else $error("usage not taken");
    AST_SAME_KIND: assert property (
        only_dz && en_q[2] && ctx.in_handler && !lockup
        && ctx.handler == fce_pkg::FCE_H_USAGE
        |=> dispatch.take && dispatch.handler == fce_pkg::FCE_H_HARD)
        else $error("own kind not hard");
    COV_LOCK: cover property ($rose(lockup));
    COV_HARD: cover property (
        dispatch.take && dispatch.handler == fce_pkg::FCE_H_HARD);
    COV_FREE: cover property (lockup ##1 !lockup);
endmodule
bind fce_fault_unit fce_fault_unit_chk #(.ADDR_W(ADDR_W)) i_chk (
    .mclk(mclk), .arst_n(arst_n), .events(events), .ctx(ctx), .nmi(nmi),
    .debug_halt(debug_halt), .addr(addr), .wdata(wdata), .wr(wr),
    .dispatch(dispatch), .lockup(lockup)
);
`default_nettype wire

// File: tb/fce_core_model.sv
// behavioural model of pipeline, bus interface and protection unit
`timescale 1ns/100ps
`default_nettype none
module fce_core_model (
    input  wire logic           mclk,
    input  wire logic           arst_n,
    input  wire logic           fire,
    input  wire logic [17:0]    ev_mask,
    input  wire logic [31:0]    ev_data,
    output fce_pkg::fce_events_t events,
    output logic [31:0]         fault_addr,
    output logic [31:0]         exception_return_value
);
    // ----------
    // event pulses
    // ----------
    // data toggle between events so stale values never match
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            events                 <= 18'h00000;
            fault_addr             <= 32'h00000000;
            exception_return_value <= 32'h00000000;
        end else begin
            events                 <= fire ? ev_mask : 18'h00000;
            fault_addr             <= fire ? ev_data : ~fault_addr;
            exception_return_value <= fire ? ev_data : ~exception_return_value;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the fault classify/escalate unit
`timescale 1ns/100ps
`default_nettype none
`include "fce_cfg.svh"
module tb_top;
    logic                   mclk;
    logic                   arst_n;
    logic                   fire;
    logic [17:0]            ev_mask;
    logic [31:0]            ev_data;
    fce_pkg::fce_events_t   events;
    logic [31:0]            ret_val;
    logic [31:0]            f_addr;
    fce_pkg::fce_context_t  ctx;
    logic                   nmi;
    logic                   debug_halt;
    logic [7:0]             addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
    logic [31:0]            rdata;
    fce_pkg::fce_dispatch_t dispatch;
    logic                   lockup;
    int                     error_cnt;
    int                     samples_checked;
    // fault table: event mask, status offset, expected flag
    logic [17:0] t_m [18] = '{18'h20000, 18'h10000, 18'h08000, 18'h04000,
        18'h02000, 18'h01000, 18'h00800, 18'h00400, 18'h00200, 18'h00180,
        18'h00100, 18'h00040, 18'h00020, 18'h00010, 18'h00008, 18'h00004,
        18'h00002, 18'h00001};
    logic [7:0]  t_o [18] = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04,
        8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h0C, 8'h0C,
        8'h0C, 8'h0C, 8'h0C};
    logic [5:0]  t_f [18] = '{6'h01, 6'h01, 6'h01, 6'h02, 6'h08, 6'h04,
        6'h10, 6'h08, 6'h01, 6'h02, 6'h04, 6'h08, 6'h01, 6'h02, 6'h02,
        6'h04, 6'h10, 6'h20};
    logic [31:0] t_r [4] = '{32'hFFFFFFF1, 32'hFFFFFFF9, 32'hFFFFFFFD,
        32'h7FFFFFF9};
    fce_core_model i_src (
        .mclk(mclk), .arst_n(arst_n), .fire(fire), .ev_mask(ev_mask),
        .ev_data(ev_data), .events(events), .fault_addr(f_addr),
        .exception_return_value(ret_val)
    );
    fce_fault_unit #(.ADDR_W(8)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .events(events),
        .exception_return_value(ret_val), .fault_addr(f_addr), .ctx(ctx),
        .nmi(nmi), .debug_halt(debug_halt), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .dispatch(dispatch), .lockup(lockup)
    );
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    // ----------
    // access tasks
    // ----------
    function automatic fce_pkg::fce_handler_t hnd(input logic [7:0] o);
        case (o)
            `FCE_OFF_MMFSR: return fce_pkg::FCE_H_MEM;
            `FCE_OFF_BFSR:  return fce_pkg::FCE_H_BUS;
            `FCE_OFF_UFSR:  return fce_pkg::FCE_H_USAGE;
            default:        return fce_pkg::FCE_H_HARD;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic lk(input logic e);
        chk("lockup", {31'h0, e}, {31'h0, lockup});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge mclk);
        wr    <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge mclk);
        rd   <= 1'h0;
        #1;
        chk($sformatf("reg %h", a), e, rdata);
        @(posedge mclk) #1 chk("rdata idle", 32'h0, rdata);
    endtask
    task automatic fault(input logic [17:0] m, input logic [31:0] d,
                         input logic tk, input fce_pkg::fce_handler_t h);
        @(posedge mclk);
        fire    <= 1'h1;
        ev_mask <= m;
        ev_data <= d;
        @(posedge mclk);
        fire    <= 1'h0;
        @(posedge mclk);
        #1;
        chk("take", {31'h0, tk}, {31'h0, dispatch.take});
        if (tk)
            chk("handler", {29'h0, h}, {29'h0, dispatch.handler});
    endtask
    task automatic pulse(input logic dbg);
        @(posedge mclk);
        nmi        <= !dbg;
        debug_halt <= dbg;
        @(posedge mclk);
        nmi        <= 1'h0;
        debug_halt <= 1'h0;
        #1;
    endtask
    task automatic at(input fce_pkg::fce_handler_t h, input logic [7:0] p);
        @(posedge mclk);
        ctx <= {h, p, 1'h1};
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // a hang is cut short here and counted
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up;
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        {arst_n, fire, nmi, debug_halt, wr, rd} = 6'h00;
        {ev_mask, ev_data, addr, wdata} = 90'h0;
        ctx = {fce_pkg::FCE_H_NONE, 8'hFF, 1'h0};
        error_cnt = 0;
        samples_checked = 0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'h1;
        for (int i = 0; i < 10; i++) rd_chk(8'(i * 4), 32'h0);
        wr_reg(8'h24, 32'hFFFFFFFF);
        $display("test reset_values done");
        fault(18'h00001, 32'h0, 1'h1, fce_pkg::FCE_H_HARD);
        rd_chk(`FCE_OFF_HFSR, 32'h2);
        rd_chk(`FCE_OFF_UFSR, 32'h20);
        wr_reg(`FCE_OFF_HFSR, 32'hFFFFFFFF);
        wr_reg(`FCE_OFF_UFSR, 32'hFFFFFFFF);
        wr_reg(`FCE_OFF_PRI, 32'h00302010);
        wr_reg(`FCE_OFF_EN, 32'h7);
        rd_chk(`FCE_OFF_PRI, 32'h00302010);
        rd_chk(`FCE_OFF_EN, 32'h7);
        rd_chk(`FCE_OFF_HFSR, 32'h0);
        $display("test escalate_disabled done");
        for (int i = 0; i < 18; i++) begin
            fault(t_m[i], 32'hFFFFFFF0, 1'h1, hnd(t_o[i]));
            rd_chk(t_o[i], {26'h0, t_f[i]});
            wr_reg(t_o[i], 32'hFFFFFFFF);
            rd_chk(t_o[i], 32'h0);
        end
        for (int i = 0; i < 4; i++)
            fault(18'h00004, t_r[i], i == 3, fce_pkg::FCE_H_USAGE);
        rd_chk(`FCE_OFF_UFSR, 32'h4);
        fault(18'h04000, 32'h20001234, 1'h1, fce_pkg::FCE_H_MEM);
        fault(18'h00180, 32'h40000010, 1'h1, fce_pkg::FCE_H_BUS);
        rd_chk(`FCE_OFF_MMAR, 32'h20001234);
        rd_chk(`FCE_OFF_BFAR, 32'h40000010);
        $display("test fault_table done");
        at(fce_pkg::FCE_H_OTHER, 8'h30);
        fault(18'h00001, 32'h0, 1'h1, fce_pkg::FCE_H_HARD);
        rd_chk(`FCE_OFF_HFSR, 32'h2);
        at(fce_pkg::FCE_H_OTHER, 8'h31);
        fault(18'h00001, 32'h0, 1'h1, fce_pkg::FCE_H_USAGE);
        at(fce_pkg::FCE_H_USAGE, 8'hFF);
        fault(18'h00001, 32'h0, 1'h1, fce_pkg::FCE_H_HARD);
        at(fce_pkg::FCE_H_BUS, 8'hFF);
        fault(18'h00800, 32'h0, 1'h1, fce_pkg::FCE_H_BUS);
        at(fce_pkg::FCE_H_OTHER, 8'h00);
        fault(18'h20000, 32'h0, 1'h1, fce_pkg::FCE_H_HARD);
        $display("test escalation done");
        at(fce_pkg::FCE_H_HARD, 8'h00);
        fault(18'h20000, 32'h0, 1'h0, fce_pkg::FCE_H_HARD);
        lk(1'h1);
        rd_chk(`FCE_OFF_STATE, 32'h1);
        fault(18'h00001, 32'h0, 1'h0, fce_pkg::FCE_H_USAGE);
        pulse(1'h0);
        lk(1'h0);
        at(fce_pkg::FCE_H_NMI, 8'h00);
        fault(18'h00001, 32'h0, 1'h0, fce_pkg::FCE_H_USAGE);
        rd_chk(`FCE_OFF_STATE, 32'h3);
        pulse(1'h0);
        lk(1'h1);
        pulse(1'h1);
        lk(1'h0);
        fault(18'h20000, 32'h0, 1'h0, fce_pkg::FCE_H_HARD);
        @(posedge mclk);
        arst_n <= 1'h0;
        repeat (2) @(posedge mclk);
        #1;
        lk(1'h0);
        @(posedge mclk);
        arst_n <= 1'h1;
        rd_chk(`FCE_OFF_STATE, 32'h0);
        rd_chk(`FCE_OFF_EN, 32'h0);
        $display("test lockup done");
        wrap_up;
    end
endmodule
`default_nettype wire
